// ===== core/pmtr_defs.svh
`ifndef PMTR_DEFS_SVH
`define PMTR_DEFS_SVH

// APB register offsets (byte addresses)
`define PMTR_OFF_CMD      12'h000
`define PMTR_OFF_STATUS   12'h004
`define PMTR_OFF_VECTOR   12'h008
`define PMTR_OFF_PC       12'h00C
// Data memory window: paddr[11:10] == 2'b01, word per data address
`define PMTR_WIN_SEL      2'h1

// Command and status fields
`define PMTR_CMD_LAST_BIT 8
`define PMTR_STS_BUSY_BIT 0
`define PMTR_STS_DONE_BIT 1

// Special function register locations in data memory
`define PMTR_SFR_BP       8'h04
`define PMTR_SFR_TBLP     8'h07
`define PMTR_SFR_TABLE_HIGH_BYTE_LATCH     8'h08
`define PMTR_SFR_TBHP     8'h1F

// General purpose area and banking
`define PMTR_GP_BASE      8'h40
`define PMTR_GP_BANK_SIZE 10'h0C0
`define PMTR_DM_DEPTH     10'h300

// Program memory addressing
`define PMTR_LAST_PAGE    7'h7F
`define PMTR_HIGH_MASK    8'hFF
`define PMTR_BANK0        2'h0
`define PMTR_VEC_PAD      5'h00

// Reset values
`define PMTR_RST_BYTE     8'h00
`define PMTR_RST_HI       7'h00
`define PMTR_RST_BANK     2'h0
`define PMTR_RST_PC       15'h0000

`endif

// ===== core/pmtr_pkg.sv
package pmtr_pkg;

   typedef logic [7:0]  pmtr_byte_t;
   typedef logic [14:0] pmtr_pm_addr_t;
   typedef logic [15:0] pmtr_word_t;
   typedef logic [9:0]  pmtr_dm_idx_t;
   typedef logic [1:0]  pmtr_bank_t;

   typedef enum logic [2:0] {
      PMTR_IDLE  = 3'b001,
      PMTR_FETCH = 3'b010,
      PMTR_XFER  = 3'b100
   } pmtr_state_e;

endpackage

// ===== core/pmtr_dmem.sv
`timescale 1ns/1ns
`include "pmtr_defs.svh"

module pmtr_dmem (
   input  wire logic                 sys_clk,
   input  wire logic                 we,
   input  wire pmtr_pkg::pmtr_dm_idx_t widx,
   input  wire pmtr_pkg::pmtr_byte_t   wdata,
   input  wire pmtr_pkg::pmtr_dm_idx_t ridx,
   output      pmtr_pkg::pmtr_byte_t   rdata
);
   import pmtr_pkg::*;

   // Four banks of general purpose bytes, no reset: plain RAM
   pmtr_byte_t mem [0:`PMTR_DM_DEPTH-1];

   // Single write port
   always_ff @(posedge sys_clk) begin
      if (we && (widx < `PMTR_DM_DEPTH)) begin
         mem[widx] <= wdata;
      end
   end

   // Asynchronous read; caller registers the result
   assign rdata = (ridx < `PMTR_DM_DEPTH) ? mem[ridx] : `PMTR_RST_BYTE;

endmodule

// ===== core/pmtr_core.sv
`timescale 1ns/1ns
`include "pmtr_defs.svh"

module pmtr_core (
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output      logic [31:0]              prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   // Program memory port (synchronous read)
   output      pmtr_pkg::pmtr_pm_addr_t  pm_addr,
   output      logic                     pm_rd,
   input  wire pmtr_pkg::pmtr_word_t     pm_data,
   // Observed state
   output      logic                     table_busy,
   output      pmtr_pkg::pmtr_byte_t     table_high_byte_latch,
   output      pmtr_pkg::pmtr_bank_t     bank_select_pointer,
   output      pmtr_pkg::pmtr_pm_addr_t  program_counter
);
   import pmtr_pkg::*;

   // Sequencer state
   pmtr_state_e   state_q;
   pmtr_state_e   state_d;
   logic          busy_q;
   logic          done_q;
   logic          last_q;
   pmtr_byte_t    dest_q;
   pmtr_pm_addr_t pm_addr_q;
   logic          pm_rd_q;

   // Special function registers
   pmtr_byte_t    tbl_lo_q;
   logic [6:0]    tbl_hi_q;
   pmtr_byte_t    latch_q;
   pmtr_bank_t    bp_q;
   pmtr_pm_addr_t pc_q;

   // APB answer registers
   logic          pready_q;
   logic          pslverr_q;
   logic [31:0]   prdata_q;
   logic [31:0]   rd_d;
   logic          err_d;

   // Bus decode
   logic          win_hit;
   logic          acc;
   logic          wr_acc;
   logic          stall;
   logic          answer;
   pmtr_byte_t    dm_addr;
   logic          cmd_wr;
   logic          sts_wr;
   logic          vec_wr;
   logic          pc_wr;
   logic          start;

   // Data memory write and read paths
   logic          xfer;
   logic          dm_wr_en;
   pmtr_byte_t    dm_wr_addr;
   pmtr_byte_t    dm_wr_data;
   logic          ram_we;
   pmtr_dm_idx_t  ram_widx;
   pmtr_dm_idx_t  ram_ridx;
   pmtr_byte_t    ram_rdata;
   pmtr_byte_t    dm_rd_val;

   // Bank and offset into the flat general purpose array
   function automatic pmtr_dm_idx_t gp_index(input pmtr_bank_t bank,
                                             input pmtr_byte_t addr);
      pmtr_dm_idx_t base;
      pmtr_dm_idx_t off;
      base = pmtr_dm_idx_t'({8'h00, bank} * `PMTR_GP_BANK_SIZE);
      off  = pmtr_dm_idx_t'({2'h0, addr} - {2'h0, `PMTR_GP_BASE});
      return pmtr_dm_idx_t'(base + off);
   endfunction

   // Address decode, data window or register block
   assign win_hit = (paddr[11:10] == `PMTR_WIN_SEL);
   assign dm_addr = paddr[9:2];
   assign acc     = psel & penable & pready_q;
   assign wr_acc  = acc & pwrite;
   assign cmd_wr  = wr_acc & ~win_hit & (paddr == `PMTR_OFF_CMD);
   assign sts_wr  = wr_acc & ~win_hit & (paddr == `PMTR_OFF_STATUS);
   assign vec_wr  = wr_acc & ~win_hit & (paddr == `PMTR_OFF_VECTOR);
   assign pc_wr   = wr_acc & ~win_hit & (paddr == `PMTR_OFF_PC);
   // Window traffic waits for a table read to finish; avoids RAM clash
   assign stall   = win_hit & busy_q;
   assign answer  = psel & ~pready_q & ~stall;
   // Commands while busy are dropped, not queued
   assign start   = cmd_wr & (state_q == PMTR_IDLE);

   // Next state of the two-cycle table read
   always_comb begin
      state_d = state_q;
      case (state_q)
         PMTR_IDLE: begin
            if (start) begin
               state_d = PMTR_FETCH;
            end
         end
         PMTR_FETCH: begin
            state_d = PMTR_XFER;
         end
         PMTR_XFER: begin
            state_d = PMTR_IDLE;
         end
         default: begin
            state_d = PMTR_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= PMTR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Busy flag seen by software and the bus stall
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != PMTR_IDLE);
      end
   end

   // Completion flag; a finishing read beats a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         done_q <= 1'b0;
      end else if (state_q == PMTR_XFER) begin
         done_q <= 1'b1;
      end else if (sts_wr && pwdata[`PMTR_STS_DONE_BIT]) begin
         done_q <= 1'b0;
      end
   end

   // Operand and page mode captured with the command
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dest_q <= `PMTR_RST_BYTE;
         last_q <= 1'b0;
      end else if (start) begin
         dest_q <= pwdata[7:0];
         last_q <= pwdata[`PMTR_CMD_LAST_BIT];
      end
   end

   // Word address frozen at start; pointer writes later do not disturb it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pm_addr_q <= `PMTR_RST_PC;
      end else if (start) begin
         if (pwdata[`PMTR_CMD_LAST_BIT]) begin
            pm_addr_q <= {`PMTR_LAST_PAGE, tbl_lo_q};
         end else begin
            pm_addr_q <= {tbl_hi_q, tbl_lo_q};
         end
      end
   end

   // Read strobe for the single fetch cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pm_rd_q <= 1'b0;
      end else begin
         pm_rd_q <= start;
      end
   end

   // Memory answers one cycle after the strobe, in the transfer cycle
   assign xfer = (state_q == PMTR_XFER);

   // High byte into the latch; no software path reaches it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         latch_q <= `PMTR_RST_BYTE;
      end else if (xfer) begin
         latch_q <= pm_data[15:8] & `PMTR_HIGH_MASK;
      end
   end

   // Shared data memory write port, table transfer first
   always_comb begin
      dm_wr_en   = xfer | (wr_acc & win_hit);
      dm_wr_addr = xfer ? dest_q : dm_addr;
      dm_wr_data = xfer ? pm_data[7:0] : pwdata[7:0];
      ram_we     = dm_wr_en & (dm_wr_addr >= `PMTR_GP_BASE);
      ram_widx   = gp_index(bp_q, dm_wr_addr);
      ram_ridx   = gp_index(bp_q, dm_addr);
   end

   // Banked general purpose storage
   pmtr_dmem u_dmem (
      .sys_clk (sys_clk),
      .we      (ram_we),
      .widx    (ram_widx),
      .wdata   (dm_wr_data),
      .ridx    (ram_ridx),
      .rdata   (ram_rdata)
   );

   // Bank pointer; also picks the program bank on a jump
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bp_q <= `PMTR_RST_BANK;
      end else if (dm_wr_en && (dm_wr_addr == `PMTR_SFR_BP)) begin
         bp_q <= dm_wr_data[1:0];
      end
   end

   // Table pointers, writable as ordinary special registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tbl_lo_q <= `PMTR_RST_BYTE;
         tbl_hi_q <= `PMTR_RST_HI;
      end else if (dm_wr_en) begin
         if (dm_wr_addr == `PMTR_SFR_TBLP) begin
            tbl_lo_q <= dm_wr_data;
         end
         if (dm_wr_addr == `PMTR_SFR_TBHP) begin
            tbl_hi_q <= dm_wr_data[6:0];
         end
      end
   end

   // Program counter: vector entry lands in bank zero, pointer untouched
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pc_q <= `PMTR_RST_PC;
      end else if (vec_wr) begin
         pc_q <= {`PMTR_BANK0, `PMTR_VEC_PAD, pwdata[7:0]};
      end else if (pc_wr) begin
         pc_q <= {bp_q, pwdata[12:0]};
      end
   end

   // Special area decode; unused and latch-only slots behave per map
   always_comb begin
      dm_rd_val = `PMTR_RST_BYTE;
      if (dm_addr >= `PMTR_GP_BASE) begin
         dm_rd_val = ram_rdata;
      end else begin
         case (dm_addr)
            `PMTR_SFR_BP: begin
               dm_rd_val = {6'h00, bp_q};
            end
            `PMTR_SFR_TBLP: begin
               dm_rd_val = tbl_lo_q;
            end
            `PMTR_SFR_TABLE_HIGH_BYTE_LATCH: begin
               dm_rd_val = latch_q;
            end
            `PMTR_SFR_TBHP: begin
               dm_rd_val = {1'b0, tbl_hi_q};
            end
            default: begin
               dm_rd_val = `PMTR_RST_BYTE;
            end
         endcase
      end
   end

   // Register block read mux; unknown offsets answer with an error
   always_comb begin
      rd_d  = '0;
      err_d = 1'b0;
      if (win_hit) begin
         rd_d = {24'h000000, dm_rd_val};
      end else begin
         case (paddr)
            `PMTR_OFF_CMD: begin
               rd_d = {23'h000000, last_q, dest_q};
            end
            `PMTR_OFF_STATUS: begin
               rd_d[`PMTR_STS_BUSY_BIT] = busy_q;
               rd_d[`PMTR_STS_DONE_BIT] = done_q;
            end
            `PMTR_OFF_VECTOR: begin
               rd_d = '0;
            end
            `PMTR_OFF_PC: begin
               rd_d = {17'h00000, pc_q};
            end
            default: begin
               err_d = 1'b1;
            end
         endcase
      end
   end

   // Ready one cycle after setup, later while the window is stalled
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= answer;
      end
   end

   // Answer data and error registered with ready
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else if (answer) begin
         prdata_q  <= rd_d;
         pslverr_q <= err_d;
      end
   end

   // Outputs, each straight from its flip-flop
   assign prdata                = prdata_q;
   assign pready                = pready_q;
   assign pslverr               = pslverr_q;
   assign pm_addr               = pm_addr_q;
   assign pm_rd                 = pm_rd_q;
   assign table_busy            = busy_q;
   assign table_high_byte_latch = latch_q;
   assign bank_select_pointer   = bp_q;
   assign program_counter       = pc_q;

endmodule

// ===== tb/pmtr_core_assertions.sv
`timescale 1ns/1ns
module pmtr_core_assertions (
   input wire logic                    sys_clk,
   input wire logic                    resetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire pmtr_pkg::pmtr_pm_addr_t pm_addr,
   input wire logic                    pm_rd,
   input wire pmtr_pkg::pmtr_word_t    pm_data,
   input wire logic                    table_busy,
   input wire pmtr_pkg::pmtr_byte_t    table_high_byte_latch,
   input wire pmtr_pkg::pmtr_bank_t    bank_select_pointer,
   input wire pmtr_pkg::pmtr_pm_addr_t program_counter
);
   import pmtr_pkg::*;
   logic       wr;
   pmtr_byte_t pm_hi;
   pmtr_byte_t wd_lo;
   pmtr_bank_t wd_bk;
   pmtr_byte_t lo_q;
   pmtr_byte_t hi_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Write access edge and slices that $past cannot take itself
   assign wr = psel && penable && pready && pwrite;
   assign pm_hi = pm_data[15:8];
   assign wd_lo = pwdata[7:0];
   assign wd_bk = pwdata[1:0];
   // Pointer shadows; no reset, the bench loads them before any read
   always_ff @(posedge sys_clk) begin
      if (wr && paddr == 12'h41C) lo_q <= pwdata[7:0];
      if (wr && paddr == 12'h47C) hi_q <= pwdata[7:0];
   end
   cur_page_a: assert property (
      wr && paddr == 12'h000 && !table_busy && !pwdata[8]
      |=> pm_addr == {hi_q[6:0], lo_q}) else $error("current page address");
   last_page_a: assert property (
      wr && paddr == 12'h000 && !table_busy && pwdata[8]
      |=> pm_addr == {7'h7F, lo_q}) else $error("last page address");
   fetch_pulse_a: assert property (
      $rose(table_busy) |-> pm_rd ##1 !pm_rd) else $error("fetch strobe");
   two_cycle_a: assert property (
      $rose(table_busy) |=> table_busy ##1 !table_busy)
      else $error("busy length");
   addr_hold_a: assert property (
      table_busy |=> $stable(pm_addr)) else $error("address moved");
   latch_load_a: assert property (
      $fell(table_busy) |-> table_high_byte_latch == $past(pm_hi))
      else $error("latch load");
   latch_ro_a: assert property (
      $changed(table_high_byte_latch) |-> $fell(table_busy))
      else $error("latch changed");
   vector_keep_a: assert property (
      wr && paddr == 12'h008 |=> $stable(bank_select_pointer)
      && program_counter == {7'h00, $past(wd_lo)}) else $error("vector");
   bank_set_a: assert property (
      wr && paddr == 12'h410 |=> bank_select_pointer == $past(wd_bk))
      else $error("bank write");
   pc_bank_a: assert property (
      wr && paddr == 12'h00C
      |=> program_counter[14:13] == $past(bank_select_pointer))
      else $error("pc bank");
   bad_addr_a: assert property (
      psel && penable && pready && paddr == 12'h010
      |-> pslverr && prdata == 32'h0) else $error("unmapped");
   cover property (wr && paddr == 12'h000 && pwdata[8]);
   cover property ($fell(table_busy));
   cover property (wr && paddr == 12'h008);
endmodule
bind pmtr_core pmtr_core_assertions pmtr_core_assertions_inst (
   .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .pm_addr, .pm_rd, .pm_data, .table_busy,
   .table_high_byte_latch, .bank_select_pointer, .program_counter);

// ===== tb/pmtr_pmem_model.sv
`timescale 1ns/1ns
module pmtr_pmem_model (
   input wire logic                    sys_clk,
   input wire pmtr_pkg::pmtr_pm_addr_t pm_addr,
   input wire logic                    pm_rd,
   output     pmtr_pkg::pmtr_word_t    pm_data
);
   import pmtr_pkg::*;
   // Whole 32K word space, contents derived from the address
   function automatic pmtr_word_t word_at(input pmtr_pm_addr_t a);
      return {a[7:0] ^ 8'h5A, a[14:7]};
   endfunction
   // Word valid one cycle only; inverted after so a late sample shows
   initial pm_data = 16'hA5C3;
   always @(posedge sys_clk) begin
      if (pm_rd)
         pm_data <= word_at(pm_addr);
      else
         pm_data <= ~pm_data;
   end
endmodule

// ===== tb/program_memory_table_read_test.sv
`timescale 1ns/1ns
module program_memory_table_read_test;
   import pmtr_pkg::*;
   logic          sys_clk;
   logic          resetn;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [11:0]   paddr;
   logic [31:0]   pwdata;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   pmtr_pm_addr_t pm_addr;
   logic          pm_rd;
   pmtr_word_t    pm_data;
   logic          table_busy;
   pmtr_byte_t    table_high_byte_latch;
   pmtr_bank_t    bank_select_pointer;
   pmtr_pm_addr_t program_counter;
   int            failures;
   int            n_checks;
   logic [31:0]   rng;
   logic [31:0]   rd;
   logic          er;
   pmtr_byte_t    sav;
   pmtr_core pmtr_core_inst (
      .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pm_addr, .pm_rd, .pm_data, .table_busy,
      .table_high_byte_latch, .bank_select_pointer, .program_counter);
   pmtr_pmem_model pmtr_pmem_model_inst (
      .sys_clk, .pm_addr, .pm_rd, .pm_data);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic pmtr_word_t word_at(input pmtr_pm_addr_t a);
      return {a[7:0] ^ 8'h5A, a[14:7]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One APB transfer; an idle cycle after keeps psel single-driven
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Wait states are the slave's business; the watchdog ends a hang
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic dw(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, {2'b01, a, 2'b00}, {24'h0, d});
   endtask
   task automatic dr(input logic [7:0] a);
      apb(1'b0, {2'b01, a, 2'b00}, 32'h0);
   endtask
   // Point, fire, count busy cycles, then check both bytes, or the high byte twice when the target is the latch slot
   task automatic tread(input logic [7:0] lo, input logic [6:0] hi,
                        input logic last, input logic [7:0] dst);
      pmtr_pm_addr_t a;
      pmtr_word_t    w;
      int            n;
      a = last ? {7'h7F, lo} : {hi, lo};
      w = word_at(a);
      dw(8'h07, lo);
      dw(8'h1F, {1'b0, hi});
      apb(1'b1, 12'h000, {23'h0, last, dst});
      n = 0;
      while (table_busy !== 1'b0 && n < 10) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n, 2);
      chk(pm_addr, a);
      chk(table_high_byte_latch, w[15:8]);
      dr(dst);
      chk(rd, dst == 8'h08 ? w[15:8] : w[7:0]);
   endtask
   initial begin
      #500000;
      failures++;
      report_and_stop();
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      failures = 0;
      n_checks = 0;
      rng = 32'h42;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(32'({table_high_byte_latch, bank_select_pointer}), 32'h0);
      chk(program_counter, 32'h0);
      $display("test reset done");
      // Extreme pointers, both pages, latch slot and pointer as target
      tread(8'hFF, 7'h7F, 1'b0, 8'h40);
      tread(8'h00, 7'h00, 1'b1, 8'hFF);
      tread(8'h05, 7'h20, 1'b0, 8'h08);
      tread(8'h3C, 7'h11, 1'b1, 8'h07);
      // Completion flag sticks, then clears on a one written to it
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 12'h004, 32'h2);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      // Pointer write right behind a command stalls; address stays put
      dw(8'h07, 8'h12);
      dw(8'h1F, 8'h34);
      apb(1'b1, 12'h000, 32'h41);
      dw(8'h07, 8'h99);
      chk(pm_addr, 32'h3412);
      chk(table_high_byte_latch, 32'({word_at(15'h3412)} >> 8));
      dr(8'h41);
      chk(rd, 32'(word_at(15'h3412) & 16'h00FF));
      dr(8'h07);
      chk(rd, 32'h99);
      $display("test corners done");
      // Only this process reads tables, so the latch is never shared
      for (int i = 0; i < 16; i++) begin
         rng = xs(rng);
         dw(8'h04, {6'h0, rng[25:24]});
         tread(rng[7:0], rng[14:8], rng[15], rng[23:16] | 8'h40);
      end
      $display("test random reads done");
      // Software write must not reach the latch
      sav = table_high_byte_latch;
      dw(8'h08, ~sav);
      chk(table_high_byte_latch, sav);
      dr(8'h08);
      chk(rd, sav);
      // Same address in each bank holds its own byte
      for (int b = 0; b < 4; b++) begin
         dw(8'h04, 8'(b));
         dw(8'h90, 8'hA0 + 8'(b));
      end
      for (int b = 0; b < 4; b++) begin
         dw(8'h04, 8'(b));
         dr(8'h90);
         chk(rd, 32'hA0 + b);
      end
      dr(8'h05);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test memory map done");
      // Entry from bank 2 to both vectors; handler saves and restores
      for (int v = 4; v <= 8; v += 4) begin
         dw(8'h04, 8'h02);
         apb(1'b1, 12'h008, 32'(v));
         chk(program_counter, 32'(v));
         chk(bank_select_pointer, 2'h2);
         dr(8'h04);
         sav = rd[7:0];
         dw(8'h04, 8'h00);
         chk(bank_select_pointer, 2'h0);
         dw(8'h04, sav);
         chk(bank_select_pointer, 2'h2);
      end
      apb(1'b1, 12'h00C, 32'h1FFF);
      chk(program_counter, {2'h2, 13'h1FFF});
      $display("test vectors done");
      report_and_stop();
   end
endmodule
